// ===== core/bra_map.svh
// register offsets, field positions and reset values of the buffer read aligner
`ifndef BRA_MAP_SVH
`define BRA_MAP_SVH
`define BRA_LOC_W 3
`define BRA_CTRL_OFS 32'h0000_0000
`define BRA_STAT_OFS 32'h0000_0004
`define BRA_DATA_OFS 32'h0000_0008
`define BRA_CTRL_RST 32'h0000_0000
`define BRA_C_WIDTH 0
`define BRA_C_DIN 2
`define BRA_C_END 3
`define BRA_C_RSTATE 4
`define BRA_C_CONDA 5
`define BRA_C_CONDB 6
`define BRA_C_CONDC 7
`define BRA_C_BELOW5 8
`define BRA_S_KPRES 0
`define BRA_S_FULL 4
`define BRA_S_AGAIN 5
`define BRA_S_ENDEMPTY 6
`define BRA_S_PHASE 7
`define BRA_S_EMPTY 8
`define BRA_S_LOC 12
`define BRA_S_ROUTE 16
`endif

// ===== core/bra_pkg.sv
// shared types of the buffer read aligner
package bra_pkg;
   typedef enum logic [1:0] {W_SINGLE, W_TWO, W_FOUR, W_RSVD} width_t;
   typedef struct packed {
      logic [3:0][7:0] data;
      logic [3:0] present;
   } lane_word_t;
endpackage

// ===== core/buffer_read_byte_aligner.sv
// read side of the byte-lane data buffer with lane alignment and ahb-lite control
//
// Behaviour
// - four-byte data in: force out lane D early
// - full latch sets at read delay tap
// - write phase granted on full or end-empty
// - end-empty needs end of data, empty buffer
// - source decoder picks one lowest present lane
// - selected source lane is lowest holding data
// - destination picks lowest free lane, else D
// - equal lanes path 0; up 1,3,5
// - down lanes path 6,4,2; one path only
// - lane enables: path, strobe, width qualifiers
// - per-path lane gating by interface width
// - never copy a lane without presence
// - successive reads rotate into word-aligned stream
// - one-byte writes fill lane A successively
// - clear consumed source presence after read
// - flag location needing another read
// - read location counter steps after reads
// - step counter back on re-read tap
// - buffer address comes from read counter
// - output presence follows routed source presence
// - presence mapping follows the active path
// - write phase needs lane D presence; here also granted on end-empty or on count below five when not four-byte
// - consumed output register is cleared
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`include "bra_map.svh"

module buffer_read_byte_aligner
   import bra_pkg::*;
#(
   parameter int LOC_W = `BRA_LOC_W
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // buffer write side
   input wire logic buf_write,
   input wire lane_word_t buf_wr_word,
   // read timing and output register hand-off
   input wire logic buffer_read_strobe,
   input wire logic out_take,
   output lane_word_t out_word,
   // phase control
   output logic out_full_latch,
   output logic end_and_empty,
   output logic datain_mem_write_phase
);

   localparam int DEPTH = 1 << LOC_W;

   // buffer store and state
   logic [3:0][7:0] mem_data [DEPTH];
   logic [3:0] pres_ff [DEPTH];
   logic [LOC_W-1:0] in_loc_ff, out_loc_ff, nxt_out_loc, buffer_location_addr;
   logic [1:0] wbyte_ff;
   logic [31:0] ctrl_ff, ctrl_view, addr_ff, hrdata_ff, status, rd_mux;
   logic wr_pend_ff, tap_ff, another_ff, full_ff, addr_phase;
   logic [3:0] k_pres_ff, nxt_k_pres, wr_pres;
   logic [3:0][7:0] k_data_ff, xfer_data, src_data;
   logic [3:0] src_pres, src_oh, dst_oh, gate, lane_xfer_enable, consumed;
   logic [6:0] route_sel;
   logic [2:0] lane_diff;
   logic [DEPTH-1:0] loc_busy;
   width_t width_sel;
   logic width_four_byte, width_not_four, width_single, width_not_single;
   logic data_in, end_data, buf_read_state, count_below_five;
   logic count_cond_a, count_cond_b, count_cond_c;
   logic src_any, xfer_go, force_kd, another_now, read_delay_tap;
   logic out_loc_dec_clock, full_set, buf_empty, wr_hit;
   logic src_lowest_lane_a, src_lowest_lane_b, src_lowest_lane_c, src_lowest_lane_d;
   logic dst_free_lane_a, dst_free_lane_b, dst_free_lane_c, dst_free_lane_d;

   // lowest set bit as one-hot, zero when none set
   function automatic logic [3:0] low_onehot(input logic [3:0] v);
      low_onehot = v & (~v + 4'h1);
   endfunction

   // one-hot lane to lane number
   function automatic logic [1:0] lane_idx(input logic [3:0] oh);
      lane_idx = {oh[3] | oh[2], oh[3] | oh[1]};
   endfunction

   // output lanes a path may fill, given the interface width
   function automatic logic [3:0] path_gate(input logic [6:0] rs, input logic single,
                                            input logic four);
      logic [3:0] m;
      m = 4'h0;
      if (rs[0]) m = m | {four, four, ~single, 1'b1};
      if (rs[1]) m = m | {four, ~single, 2'b10};
      if (rs[3]) m = m | {~single, 3'h4};
      if (rs[5]) m = m | 4'h8;
      if (rs[6]) m = m | {1'b0, four, four, ~single};
      if (rs[4]) m = m | 4'h3;
      if (rs[2]) m = m | 4'h1;
      path_gate = m;
   endfunction

   // software control fields
   assign width_sel = width_t'(ctrl_ff[`BRA_C_WIDTH +: 2]);
   assign width_four_byte = (width_sel == W_FOUR);
   assign width_not_four = !width_four_byte;
   assign width_single = (width_sel == W_SINGLE);
   assign width_not_single = !width_single;
   assign data_in = ctrl_ff[`BRA_C_DIN];
   assign end_data = ctrl_ff[`BRA_C_END];
   assign buf_read_state = ctrl_ff[`BRA_C_RSTATE];
   assign count_cond_a = ctrl_ff[`BRA_C_CONDA];
   assign count_cond_b = ctrl_ff[`BRA_C_CONDB];
   assign count_cond_c = ctrl_ff[`BRA_C_CONDC];
   assign count_below_five = ctrl_ff[`BRA_C_BELOW5];

   // addressed location during reads comes from the read counter
   assign buffer_location_addr = out_loc_ff;
   assign src_pres = pres_ff[buffer_location_addr];
   assign src_data = mem_data[buffer_location_addr];

   // align decoders
   assign src_any = |src_pres;
   assign src_oh = low_onehot(src_pres);
   assign dst_oh = (&k_pres_ff) ? 4'h8 : low_onehot(~k_pres_ff);
   assign {src_lowest_lane_d, src_lowest_lane_c, src_lowest_lane_b, src_lowest_lane_a} = src_oh;
   assign {dst_free_lane_d, dst_free_lane_c, dst_free_lane_b, dst_free_lane_a} = dst_oh;

   // path select from lane distance, wrapped modulo eight
   assign lane_diff = {1'b0, lane_idx(dst_oh)} - {1'b0, lane_idx(src_oh)};
   assign route_sel[0] = src_any & (lane_diff == 3'h0);
   assign route_sel[1] = src_any & (lane_diff == 3'h1);
   assign route_sel[3] = src_any & (lane_diff == 3'h2);
   assign route_sel[5] = src_any & (lane_diff == 3'h3);
   assign route_sel[6] = src_any & (lane_diff == 3'h7);
   assign route_sel[4] = src_any & (lane_diff == 3'h6);
   assign route_sel[2] = src_any & (lane_diff == 3'h5);
   assign gate = path_gate(route_sel, width_single, width_four_byte);

   // a read cycle only counts while the read state is up
   assign xfer_go = buffer_read_strobe & buf_read_state;

   // per-lane steering; the gate mask keeps wrapped indices out of range lanes
   for (genvar j = 0; j < 4; j++) begin : g_lane
      logic [1:0] sj, dj;
      assign sj = 2'(j) - lane_diff[1:0];
      assign dj = 2'(j) + lane_diff[1:0];
      assign lane_xfer_enable[j] = xfer_go & gate[j] & src_pres[sj];
      assign xfer_data[j] = src_data[sj];
      assign consumed[j] = xfer_go & gate[dj] & src_pres[j];
   end

   // early lane D presence when the count runs out first
   assign force_kd = xfer_go & data_in & width_four_byte &
                     ((src_lowest_lane_b & count_cond_a & route_sel[6]) |
                      (src_lowest_lane_c & count_cond_b & (route_sel[4] | route_sel[6])) |
                      (src_lowest_lane_d & count_cond_c &
                       (route_sel[2] | route_sel[4] | route_sel[6])));

   // output presence follows routed source presence
   assign nxt_k_pres = (out_take ? 4'h0 : k_pres_ff) | lane_xfer_enable |
                       {force_kd, 3'h0};

   // re-read and location stepping
   assign another_now = |(src_pres & ~consumed);
   assign read_delay_tap = tap_ff;
   assign out_loc_dec_clock = another_ff & buf_read_state & read_delay_tap;
   assign nxt_out_loc = out_loc_ff + LOC_W'(xfer_go) - LOC_W'(out_loc_dec_clock);

   // full latch and phase entry
   assign full_set = read_delay_tap & buf_read_state &
                     (k_pres_ff[3] | (width_not_four & count_below_five));
   for (genvar i = 0; i < DEPTH; i++) begin : g_busy
      assign loc_busy[i] = |pres_ff[i];
   end
   assign buf_empty = ~|loc_busy;
   assign end_and_empty = end_data & buf_empty;
   assign datain_mem_write_phase = data_in & (full_ff | end_and_empty);
   assign out_full_latch = full_ff;

   // one-byte interface writes one byte into lane A per location
   assign wr_pres = width_single ? {3'h0, buf_wr_word.present[wbyte_ff]}
                                 : buf_wr_word.present;
   assign wr_hit = buf_write & (in_loc_ff == out_loc_ff);

   // buffer data store, no reset needed since presence guards it
   always_ff @(posedge hclk) begin
      if (buf_write && width_single) begin
         mem_data[in_loc_ff][0] <= buf_wr_word.data[wbyte_ff];
      end else if (buf_write) begin
         mem_data[in_loc_ff] <= buf_wr_word.data;
      end
   end

   // presence store; a write to the read location wins over its clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            pres_ff[i] <= 4'h0;
         end
      end else begin
         if (xfer_go && !wr_hit) begin
            // keep lane D while a re-read is due, else retire the location
            pres_ff[out_loc_ff] <= another_now ? (src_pres & ~{1'b0, consumed[2:0]})
                                               : 4'h0;
         end
         if (buf_write) begin
            pres_ff[in_loc_ff] <= wr_pres;
         end
      end
   end

   // write counters
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_loc_ff <= '0;
         wbyte_ff <= 2'h0;
      end else if (buf_write) begin
         in_loc_ff <= in_loc_ff + LOC_W'(1);
         wbyte_ff <= wbyte_ff + {1'b0, width_single};
      end
   end

   // read timing latches
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_loc_ff <= '0;
         tap_ff <= 1'b0;
         another_ff <= 1'b0;
         full_ff <= 1'b0;
         k_pres_ff <= 4'h0;
      end else begin
         out_loc_ff <= nxt_out_loc;
         tap_ff <= xfer_go;
         another_ff <= xfer_go ? another_now : another_ff;
         full_ff <= full_set | (full_ff & ~out_take);
         k_pres_ff <= nxt_k_pres;
      end
   end

   // output data lanes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         k_data_ff <= '0;
      end else begin
         for (int j = 0; j < 4; j++) begin
            if (lane_xfer_enable[j]) begin
               k_data_ff[j] <= xfer_data[j];
            end
         end
      end
   end

   // one driver for the whole hand-off word
   assign out_word = '{data: k_data_ff, present: k_pres_ff};

   // ahb-lite slave: zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;
   assign addr_phase = hsel & htrans[1] & hready;
   // forward a pending write so a read right behind it sees the new value
   assign ctrl_view = (wr_pend_ff && addr_ff == `BRA_CTRL_OFS) ? hwdata : ctrl_ff;

   // status word
   always_comb begin
      status = 32'h0000_0000;
      status[`BRA_S_KPRES +: 4] = k_pres_ff;
      status[`BRA_S_FULL] = full_ff;
      status[`BRA_S_AGAIN] = another_ff;
      status[`BRA_S_ENDEMPTY] = end_and_empty;
      status[`BRA_S_PHASE] = datain_mem_write_phase;
      status[`BRA_S_EMPTY] = buf_empty;
      status[`BRA_S_LOC +: LOC_W] = out_loc_ff;
      status[`BRA_S_ROUTE +: 7] = route_sel;
   end

   assign rd_mux = (haddr == `BRA_CTRL_OFS) ? ctrl_view :
                   (haddr == `BRA_STAT_OFS) ? status :
                   (haddr == `BRA_DATA_OFS) ? k_data_ff : 32'h0000_0000;

   // bus registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         addr_ff <= 32'h0000_0000;
         hrdata_ff <= 32'h0000_0000;
         ctrl_ff <= `BRA_CTRL_RST;
      end else begin
         wr_pend_ff <= addr_phase & hwrite;
         addr_ff <= addr_phase ? haddr : addr_ff;
         hrdata_ff <= (addr_phase && !hwrite) ? rd_mux : hrdata_ff;
         ctrl_ff <= ctrl_view;
      end
   end

   // checks
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_src_onehot: assert property (
      src_any |-> $onehot(src_oh))
      else $error("source align not one-hot");
   a_src_lowest: assert property (
      src_any |-> (src_pres & (src_oh - 4'h1)) == 4'h0)
      else $error("source align not lowest lane");
   a_dst_lowest: assert property (
      $onehot(dst_oh) && ((dst_oh - 4'h1) & ~k_pres_ff) == 4'h0)
      else $error("destination align wrong");
   a_path_equal: assert property (
      src_any && src_oh == dst_oh |-> route_sel == 7'h01)
      else $error("equal lanes not path 0");
   a_path_single: assert property (
      src_any |-> $onehot(route_sel))
      else $error("path select not unique");
   a_no_void: assert property (
      $countones(lane_xfer_enable) <= $countones(src_pres))
      else $error("empty lane copied");
   a_loc_step: assert property (
      xfer_go && !out_loc_dec_clock |=> out_loc_ff == $past(out_loc_ff) + LOC_W'(1))
      else $error("read counter did not step");
   a_loc_back: assert property (
      xfer_go && another_now ##1 buf_read_state && !buffer_read_strobe
      |-> out_loc_dec_clock ##1 out_loc_ff == $past(out_loc_ff, 2))
      else $error("re-read location not restored");
   a_full_set: assert property (
      read_delay_tap && buf_read_state && k_pres_ff[3] |=> out_full_latch)
      else $error("full latch missed");
   a_phase_kd: assert property (
      datain_mem_write_phase && !end_and_empty && full_ff && !$past(out_take)
      && width_four_byte |-> k_pres_ff[3])
      else $error("write phase without lane D");
   a_take_clear: assert property (
      out_take && !xfer_go |=> out_word.present == 4'h0)
      else $error("output register not cleared");
   a_single_wr: assert property (
      buf_write |=> in_loc_ff == $past(in_loc_ff) + LOC_W'(1))
      else $error("write location did not step");

   c_route_sel_6: cover property (xfer_go && route_sel[6]);
   c_route_sel_5: cover property (xfer_go && route_sel[5]);
   c_reread: cover property (out_loc_dec_clock);
   c_phase: cover property (datain_mem_write_phase);

endmodule

// ===== testbench/ctrl_side_model.sv
// far-side model: buffer write, read strobe and output take pulses
`timescale 1ns/100ps
module ctrl_side_model
   import bra_pkg::*;
(
   // clock and pace
   input wire logic hclk,
   input wire logic slow,
   // pulses toward the aligner
   output logic buf_write,
   output lane_word_t buf_wr_word,
   output logic buffer_read_strobe,
   output logic out_take
);
   // quiet lines until the first request
   initial begin
      buf_write = 1'b0;
      buf_wr_word = '0;
      buffer_read_strobe = 1'b0;
      out_take = 1'b0;
   end
   // a slow far side leaves extra idle cycles between requests
   task automatic idle();
      repeat (slow ? 4 : 1) @(posedge hclk);
   endtask
   // released word lines carry the inverse so stale data never looks valid
   task automatic pulse_wr(input lane_word_t w);
      @(posedge hclk);
      buf_write <= 1'b1;
      buf_wr_word <= w;
      @(posedge hclk);
      buf_write <= 1'b0;
      buf_wr_word <= ~w;
      idle();
   endtask
   // strobe, then let the delay tap edge pass before anything else
   task automatic strobe();
      @(posedge hclk);
      buffer_read_strobe <= 1'b1;
      @(posedge hclk);
      buffer_read_strobe <= 1'b0;
      @(posedge hclk);
      idle();
   endtask
   // output register consumed
   task automatic take();
      @(posedge hclk);
      out_take <= 1'b1;
      @(posedge hclk);
      out_take <= 1'b0;
      idle();
   endtask
endmodule

// ===== testbench/buffer_read_byte_aligner_test.sv
// self-checking bench for the buffer read aligner with a lane-level model
`timescale 1ns/100ps
`include "bra_map.svh"
module buffer_read_byte_aligner_test;
   import bra_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = '0;
   logic slow = 1'b0;
   logic hready, hresp, buf_write, buffer_read_strobe, out_take;
   logic [31:0] hrdata;
   lane_word_t buf_wr_word, out_word;
   logic out_full_latch, end_and_empty, datain_mem_write_phase;
   int failures = 0;
   int n_checks = 0;
   int seed = 32'h0fc5_4893;
   // model: buffer presence and data, output lanes, counters and control
   int mp[8];
   logic [7:0] md[8][4];
   logic [3:0] op = '0;
   logic [3:0] ov = '0;
   logic [7:0] od[4];
   int oloc = 0, iloc = 0, wb = 0, full = 0, again = 0;
   int wd = 0, din = 0, endd = 0, ron = 0, ca = 0, b5 = 0, s, d, path, lo;
   always #4 hclk = ~hclk;
   // hready is fed back from the only slave
   buffer_read_byte_aligner #(.LOC_W(3)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
      .buf_write(buf_write), .buf_wr_word(buf_wr_word), .buffer_read_strobe(buffer_read_strobe),
      .out_take(out_take), .out_word(out_word), .out_full_latch(out_full_latch),
      .end_and_empty(end_and_empty), .datain_mem_write_phase(datain_mem_write_phase));
   ctrl_side_model P (.hclk(hclk), .slow(slow), .buf_write(buf_write),
      .buf_wr_word(buf_wr_word), .buffer_read_strobe(buffer_read_strobe), .out_take(out_take));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      if (failures == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // one single transfer; the master waits for hready at both phases
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] w,
      output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= a;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   // every visible result against the model
   task automatic check_all();
      logic [31:0] st, dw, m, ev;
      int emp, ee;
      emp = 1;
      for (int i = 0; i < 8; i++)
         if (mp[i] != 0)
            emp = 0;
      ee = endd && emp;
      ev = oloc << 12 | emp << 8 | (din && (full || ee)) << 7 | ee << 6 | again << 5;
      ev = ev | full << 4 | op;
      m = {{8{ov[3]}}, {8{ov[2]}}, {8{ov[1]}}, {8{ov[0]}}};
      ahb(1'b0, `BRA_STAT_OFS, 0, st);
      chk("status", st & 32'h0000_71FF, ev);
      ahb(1'b0, `BRA_DATA_OFS, 0, dw);
      chk("data_reg", dw & m, {od[3], od[2], od[1], od[0]} & m);
      chk("out_present", out_word.present, op);
      chk("out_data", out_word.data & m, {od[3], od[2], od[1], od[0]} & m);
      chk("full", out_full_latch, full);
      chk("end_empty", end_and_empty, ee);
      chk("phase", datain_mem_write_phase, din && (full || ee));
   endtask
   task automatic ctrl();
      logic [31:0] v, r;
      v = wd | din << `BRA_C_DIN | endd << `BRA_C_END | ron << `BRA_C_RSTATE;
      v = v | ca << `BRA_C_CONDA | b5 << `BRA_C_BELOW5;
      ahb(1'b1, `BRA_CTRL_OFS, v, r);
      ahb(1'b0, `BRA_CTRL_OFS, 0, r);
      chk("ctrl", r, v);
   endtask
   function automatic lane_word_t rnd(input int l, input int h);
      lane_word_t w;
      w.data = $random(seed);
      w.present = 4'((1 << (h + 1)) - (1 << l));
      return w;
   endfunction
   task automatic put(input lane_word_t w);
      if (wd == 0) begin
         md[iloc][0] = w.data[wb];
         mp[iloc] = w.present[wb];
         wb = (wb + 1) % 4;
      end else begin
         for (int k = 0; k < 4; k++)
            md[iloc][k] = w.data[k];
         mp[iloc] = w.present;
      end
      iloc = (iloc + 1) % 8;
      P.pulse_wr(w);
   endtask
   // one read cycle: route first, then lanes, presence and counters
   task automatic rd_step();
      logic [31:0] st;
      int w, cons;
      s = 0;
      while (!mp[oloc][s])
         s++;
      d = 0;
      while (d < 3 && op[d])
         d++;
      path = (d == s) ? 0 : (d > s) ? 2 * (d - s) - 1 : 8 + 2 * (d - s);
      ahb(1'b0, `BRA_STAT_OFS, 0, st);
      chk("route", st[22:16], 1 << path);
      P.strobe();
      w = (wd == 0) ? 1 : (wd == 2) ? 4 : 2;
      cons = 0;
      for (int k = s; k < 4; k++) begin
         if (d + k - s <= 3 && mp[oloc][k] && (k < w || path == 2 || path == 4 || path == 5)) begin
            op[d + k - s] = 1'b1;
            ov[d + k - s] = 1'b1;
            od[d + k - s] = md[oloc][k];
            cons |= 1 << k;
         end
      end
      if (din && wd == 2 && s == 1 && ca && path == 6)
         op[3] = 1'b1;
      again = (mp[oloc] & ~cons) != 0;
      mp[oloc] = again ? mp[oloc] & ~(cons & 7) : 0;
      if (!again)
         oloc = (oloc + 1) % 8;
      if (op[3] || (w < 4 && b5))
         full = 1;
      #1;
      check_all();
   endtask
   task automatic take();
      P.take();
      op = '0;
      ov = '0;
      full = 0;
      #1;
      check_all();
   endtask
   task automatic drain();
      while (mp[oloc] != 0) begin
         if (op == 4'hF)
            take();
         else
            rd_step();
      end
      take();
   endtask
   // hang guard, about 50000 cycles
   initial begin
      #400_000;
      failures++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      logic [31:0] r;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, `BRA_CTRL_OFS, 0, r);
      chk("ctrl_reset", r, `BRA_CTRL_RST);
      ahb(1'b0, 32'h0000_000C, 0, r);
      chk("unmapped", r, 32'h0000_0000);
      ahb(1'b1, `BRA_STAT_OFS, 32'hFFFF_FFFF, r);
      check_all();
      // single-byte interface: four words each put one byte into lane a of four successive locations
      ron = 1;
      b5 = 1;
      ctrl();
      repeat (4) put(rnd(0, 3));
      drain();
      // strobe without the read state is ignored
      wd = 2;
      b5 = 0;
      ron = 0;
      ctrl();
      put(rnd(0, 3));
      P.strobe();
      #1;
      check_all();
      ron = 1;
      ctrl();
      drain();
      // every source and destination pairing
      for (int dd = 0; dd < 4; dd++) begin
         for (int ss = 0; ss < 4; ss++) begin
            if (dd > 0)
               put(rnd(0, dd - 1));
            put(rnd(ss, 3));
            drain();
         end
      end
      // random contiguous lanes, far side sometimes slow
      repeat (20) begin
         slow <= ($random(seed) & 1) != 0;
         repeat (1 + $unsigned($random(seed)) % 3) begin
            lo = $unsigned($random(seed)) % 4;
            put(rnd(lo, lo + $unsigned($random(seed)) % (4 - lo)));
         end
         drain();
      end
      // two-byte interface: only lanes a and b carry data
      wd = 1;
      ctrl();
      repeat (6) begin
         repeat (2) begin
            lo = $unsigned($random(seed)) % 2;
            put(rnd(lo, lo + $unsigned($random(seed)) % (2 - lo)));
         end
         drain();
      end
      // data in: forced lane d, full latch, end with empty buffer
      wd = 2;
      din = 1;
      ca = 1;
      ctrl();
      put(rnd(1, 3));
      rd_step();
      take();
      endd = 1;
      ctrl();
      check_all();
      put(rnd(0, 3));
      check_all();
      drain();
      tally_and_finish();
   end
endmodule
